// >>> hw/cwm_top.v
// Complementary waveform generator with Wishbone classic register slave.
// Assumes data_i and fault_i are synchronous to clk_i.
//
// Overview of operation
// - Six modes chosen by mode field
// - One input, four outputs, shutdown on all but unsteered outputs, which keep override levels
// - Half bridge: A true, B inverted, dead time
// - Half bridge: C, D mirror A, B
// - Steering ignored outside steering modes
// - Push-pull alternates pulses between A, B
// - Push-pull sequencer resets on disable, shutdown
// - Sequencer advances per pulse, first on A
// - Push-pull: C, D copy A, B
// - Full bridge: three static, one modulated
// - Forward: A active, D modulated
// - Reverse: C active, B modulated
// - Lowest mode bit flips direction live
// - Direction change waits for input rise
// - Static swap, modulated waits dead band
// - Dead band only on modulated output
// - Input rise gives modulated output rise
// - Independent polarity per output
// - Two independent 6-bit dead-band timers
// - Sync steering updates at input rise
// - Async steering updates immediately
// - Polarity spares override, not steered or shutdown levels
// - Dead band counts to value, zero none
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "cwm_consts.vh"

module cwm_top #(
  parameter DBW = 6
) (
  input  wire        clk_i,    // System clock, 10 MHz
  input  wire        rst_i,    // Synchronous reset, active high
  input  wire        cyc_i,    // Wishbone cycle
  input  wire        stb_i,    // Wishbone strobe
  input  wire        we_i,     // Wishbone write enable
  input  wire [7:0]  adr_i,    // Wishbone byte address
  input  wire [3:0]  sel_i,    // Wishbone byte selects
  input  wire [31:0] dat_i,    // Wishbone write data
  output reg  [31:0] dat_o,    // Wishbone read data
  output reg         ack_o,    // Wishbone acknowledge
  input  wire        data_i,   // Pulse input, usually PWM
  input  wire        fault_i,  // Shutdown source, active high
  output reg         out_a_o,  // Output A
  output reg         out_b_o,  // Output B
  output reg         out_c_o,  // Output C
  output reg         out_d_o   // Output D
);

  // Reset images, sliced per field so no bits are dropped
  localparam [7:0] RST_CTRL  = `CWM_RST_CTRL;   // Control reset image
  localparam [3:0] RST_POL   = `CWM_RST_POL;    // Polarity reset image
  localparam [7:0] RST_STEER = `CWM_RST_STEER;  // Steering reset image
  localparam [1:0] RST_SHDN  = `CWM_RST_SHDN;   // Shutdown reset image

  // Software registers
  reg           en_reg;        // Module enable
  reg [2:0]     mode_reg;      // Mode field
  reg [3:0]     pol_reg;       // Per-output polarity, set is active high
  reg [DBW-1:0] dbr_reg;       // Rising / reverse dead band
  reg [DBW-1:0] dbf_reg;       // Falling / forward dead band
  reg [3:0]     str_reg;       // Steering selection
  reg [3:0]     ovr_reg;       // Override levels
  reg           sw_sd_reg;     // Software shutdown request
  reg           ars_reg;       // Auto-restart enable

  // Block state
  reg           in_prev_reg;   // Input one cycle ago
  reg           sd_reg;        // Shutdown active
  reg           ppn_reg;       // Push-pull side for next pulse
  reg           ppc_reg;       // Push-pull side of current pulse
  reg           dir_reg;       // Full bridge direction, 1 is reverse
  reg           blk_reg;       // Direction-change dead band pending
  reg [3:0]     strs_reg;      // Synchronised steering selection

  // Bus decode
  wire [7:0] word_adr = {adr_i[7:2], 2'b00};
  wire       req      = cyc_i & stb_i & ~ack_o;
  wire       wr       = req & we_i & sel_i[0];
  wire       rd       = req & ~we_i;

  // Mode decode
  wire hb    = (mode_reg == `CWM_MODE_HALF);
  wire pp    = (mode_reg == `CWM_MODE_PP);
  wire fb    = (mode_reg[2:1] == 2'b01);
  wire steer = (mode_reg[2:1] == 2'b00);
  wire run   = en_reg & ~sd_reg;
  wire rise  = data_i & ~in_prev_reg;

  // Shutdown sources and clear
  wire sd_src   = fault_i | sw_sd_reg;
  wire sd_wclr  = wr && (word_adr == `CWM_OFS_STAT) && dat_i[`CWM_STAT_SD];
  wire sd_clr   = (ars_reg | sd_wclr) & ~sd_src;

  // Full bridge direction handling
  wire chg     = en_reg & fb & rise & (mode_reg[0] != dir_reg);
  wire dir_eff = chg ? mode_reg[0] : dir_reg;
  wire blk_arm = chg | blk_reg;

  // Timer arming and results
  wire rise_arm;
  wire fall_arm;
  wire rise_done;
  wire fall_done;
  wire blk_next;

  assign rise_arm = run & ((hb & data_i) | (fb & blk_arm & dir_eff));
  assign fall_arm = run & ((hb & ~data_i) | (fb & blk_arm & ~dir_eff));
  assign blk_next = run & fb & blk_arm & ~(dir_eff ? rise_done : fall_done);

  cwm_dbt #(.W(DBW)) u_dbt_rise (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .arm_i  (rise_arm),
    .dly_i  (dbr_reg),
    .done_o (rise_done)
  );

  cwm_dbt #(.W(DBW)) u_dbt_fall (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .arm_i  (fall_arm),
    .dly_i  (dbf_reg),
    .done_o (fall_done)
  );

  // Push-pull side of the pulse in progress
  wire pp_side = rise ? ppn_reg : ppc_reg;

  // Effective steering selection
  reg [3:0] str_eff;

  // Steering select path
  always @* begin
    str_eff = str_reg;
    // Sync steering latched at input rise
    if (mode_reg == `CWM_MODE_SYNC) begin
      str_eff = rise ? str_reg : strs_reg;
    end
  end

  // Active sense per output, before polarity
  reg [3:0] act;
  // Output level after polarity and override
  reg [3:0] lvl;

  // Waveform generation per mode
  always @* begin
    act = 4'h0;
    lvl = 4'h0;
    case (mode_reg)
      `CWM_MODE_HALF: begin
        // True and inverted with dead time
        act[0] = data_i & rise_done;
        act[1] = ~data_i & fall_done;
        // C and D mirror A and B
        act[2] = act[0];
        act[3] = act[1];
      end
      `CWM_MODE_PP: begin
        // Alternate pulses between A and B
        act[0] = data_i & ~pp_side;
        act[1] = data_i & pp_side;
        // C and D copy A and B
        act[2] = act[0];
        act[3] = act[1];
      end
      `CWM_MODE_FWD, `CWM_MODE_REV: begin
        if (!dir_eff) begin
          act[0] = 1'b1;
          act[3] = data_i & ~blk_next;
        end else begin
          act[2] = 1'b1;
          act[1] = data_i & ~blk_next;
        end
      end
      `CWM_MODE_ASYNC, `CWM_MODE_SYNC: begin
        // Input steered to every output
        act = {4{data_i}};
      end
      default: begin
        // Reserved codes stay inactive
        act = 4'h0;
      end
    endcase
    if (!run) begin
      act = 4'h0;
    end
    lvl = ~(act ^ pol_reg);
    // Steering applies only in steering modes
    if (en_reg && steer) begin
      lvl = (lvl & str_eff) | (ovr_reg & ~str_eff);
    end
  end

  // Registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      // Inactive level for the reset polarity
      out_a_o <= ~RST_POL[0];
      out_b_o <= ~RST_POL[1];
      out_c_o <= ~RST_POL[2];
      out_d_o <= ~RST_POL[3];
    end else begin
      out_a_o <= lvl[0];
      out_b_o <= lvl[1];
      out_c_o <= lvl[2];
      out_d_o <= lvl[3];
    end
  end

  // Input edge, shutdown and sequencer state
  always @(posedge clk_i) begin
    if (rst_i) begin
      in_prev_reg <= 1'b0;
      sd_reg      <= 1'b0;
      ppn_reg     <= 1'b0;
      ppc_reg     <= 1'b0;
      dir_reg     <= 1'b0;
      blk_reg     <= 1'b0;
      strs_reg    <= RST_STEER[`CWM_STEER_STR];
    end else begin
      in_prev_reg <= data_i;
      sd_reg      <= sd_src | (sd_reg & ~sd_clr);
      if (!run) begin
        ppn_reg <= 1'b0;
        ppc_reg <= 1'b0;
      end else if (pp && rise) begin
        // Advance per pulse, first on A
        ppc_reg <= ppn_reg;
        ppn_reg <= ~ppn_reg;
      end
      if (!en_reg || !fb) begin
        dir_reg <= mode_reg[0];
      end else if (chg) begin
        dir_reg <= mode_reg[0];
      end
      blk_reg <= blk_next;
      if (!en_reg || rise) begin
        strs_reg <= str_reg;
      end
    end
  end

  // Register writes, mode bits always writable
  always @(posedge clk_i) begin
    if (rst_i) begin
      en_reg    <= RST_CTRL[`CWM_CTRL_EN];
      mode_reg  <= RST_CTRL[`CWM_CTRL_MODE];
      pol_reg   <= RST_POL;
      dbr_reg   <= `CWM_RST_DB;
      dbf_reg   <= `CWM_RST_DB;
      str_reg   <= RST_STEER[`CWM_STEER_STR];
      ovr_reg   <= RST_STEER[`CWM_STEER_OVR];
      sw_sd_reg <= RST_SHDN[`CWM_SHDN_SW];
      ars_reg   <= RST_SHDN[`CWM_SHDN_ARS];
    end else if (wr) begin
      case (word_adr)
        `CWM_OFS_CTRL: begin
          en_reg   <= dat_i[`CWM_CTRL_EN];
          mode_reg <= dat_i[`CWM_CTRL_MODE];
        end
        `CWM_OFS_POL: begin
          pol_reg <= dat_i[3:0];
        end
        `CWM_OFS_DBR: begin
          dbr_reg <= dat_i[DBW-1:0];
        end
        `CWM_OFS_DBF: begin
          dbf_reg <= dat_i[DBW-1:0];
        end
        `CWM_OFS_STEER: begin
          str_reg <= dat_i[`CWM_STEER_STR];
          ovr_reg <= dat_i[`CWM_STEER_OVR];
        end
        `CWM_OFS_SHDN: begin
          sw_sd_reg <= dat_i[`CWM_SHDN_SW];
          ars_reg   <= dat_i[`CWM_SHDN_ARS];
        end
        default: begin
          // Unmapped or status: nothing stored
          en_reg <= en_reg;
        end
      endcase
    end
  end

  // Read data mux
  reg [31:0] rdat;

  // Select read word, unmapped reads zero
  always @* begin
    rdat = 32'h0000_0000;
    case (word_adr)
      `CWM_OFS_CTRL:  rdat[7:0] = {en_reg, 4'h0, mode_reg};
      `CWM_OFS_POL:   rdat[3:0] = pol_reg;
      `CWM_OFS_DBR:   rdat[DBW-1:0] = dbr_reg;
      `CWM_OFS_DBF:   rdat[DBW-1:0] = dbf_reg;
      `CWM_OFS_STEER: rdat[7:0] = {ovr_reg, str_reg};
      `CWM_OFS_SHDN:  rdat[1:0] = {ars_reg, sw_sd_reg};
      `CWM_OFS_STAT:  rdat[7:0] = {out_d_o, out_c_o, out_b_o, out_a_o,
                                   1'b0, ppn_reg, dir_reg, sd_reg};
      default:        rdat = 32'h0000_0000;
    endcase
  end

  // Bus answer one cycle after request
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      if (rd) begin
        dat_o <= rdat;
      end
    end
  end

endmodule

`default_nettype wire

// >>> hw/cwm_consts.vh
// Constants for the complementary waveform block: register offsets,
// field positions, reset values and mode codes.
// Assumes a byte-addressed bus with one aligned 32-bit word per register.
`ifndef CWM_CONSTS_VH
`define CWM_CONSTS_VH

// Register byte offsets
`define CWM_OFS_CTRL   8'h00
`define CWM_OFS_POL    8'h04
`define CWM_OFS_DBR    8'h08
`define CWM_OFS_DBF    8'h0C
`define CWM_OFS_STEER  8'h10
`define CWM_OFS_SHDN   8'h14
`define CWM_OFS_STAT   8'h18

// Control register fields
`define CWM_CTRL_EN    7
`define CWM_CTRL_MODE  2:0

// Steering register fields
`define CWM_STEER_STR  3:0
`define CWM_STEER_OVR  7:4

// Shutdown register fields
`define CWM_SHDN_SW    0
`define CWM_SHDN_ARS   1

// Status register fields
`define CWM_STAT_SD    0
`define CWM_STAT_DIR   1
`define CWM_STAT_PP    2
`define CWM_STAT_OUT   7:4

// Reset values
`define CWM_RST_CTRL   8'h00
`define CWM_RST_POL    4'hF
`define CWM_RST_DB     6'h00
`define CWM_RST_STEER  8'h00
`define CWM_RST_SHDN   2'h0

// Mode codes
`define CWM_MODE_ASYNC 3'h0
`define CWM_MODE_SYNC  3'h1
`define CWM_MODE_FWD   3'h2
`define CWM_MODE_REV   3'h3
`define CWM_MODE_HALF  3'h4
`define CWM_MODE_PP    3'h5

`endif

// >>> hw/cwm_dbt.v
// Dead-band timer: counts clock periods from zero up to a programmed value.
// Assumes the arm input is held for the whole wait and dropped to restart.
`timescale 1ns/1ps
`default_nettype none

module cwm_dbt #(
  parameter W = 6
) (
  input  wire         clk_i,   // System clock
  input  wire         rst_i,   // Synchronous reset, active high
  input  wire         arm_i,   // Level: dead band running
  input  wire [W-1:0] dly_i,   // Programmed dead band length
  output wire         done_o   // Dead band elapsed
);

  reg [W-1:0] cnt_reg;   // Elapsed periods
  reg [W-1:0] cnt_next;  // Next count

  // Count while armed, stop at the programmed value
  always @* begin
    cnt_next = cnt_reg;
    if (!arm_i) begin
      cnt_next = {W{1'b0}};
    end else if (cnt_reg != dly_i) begin
      cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Counter register
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= {W{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Zero value gives done in the arming cycle itself
  assign done_o = arm_i & (cnt_reg == dly_i);

endmodule

`default_nettype wire

// >>> test/cwm_bridge_model.sv
// Model of the external bridge switch drivers on outputs A to D.
// Assumes pol_i gives each driver's active level, 1 meaning active high.
`timescale 1ns/1ps
`default_nettype none
module cwm_bridge_model (
  input  wire logic       clk_i,   // System clock
  input  wire logic [3:0] out_i,   // Outputs D,C,B,A
  input  wire logic [3:0] pol_i,   // Driver active levels
  output var  logic [7:0] shoot_o  // Cycles with a leg shorted
);
  wire [3:0] on = ~(out_i ^ pol_i);  // Switch conducting
  initial shoot_o = 8'h00;
  // Both switches of leg A/B or leg C/D on at once
  always @(posedge clk_i) begin
    if ((on[0] && on[1]) || (on[2] && on[3])) begin
      shoot_o <= shoot_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> test/cwm_checker.sv
// Checker of bus handshake and output levels of cwm_top.
// Assumes it is bound to cwm_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "cwm_consts.vh"
module cwm_checker #(
  parameter DBW = 6
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        data_i,
  input wire logic        fault_i,
  input wire logic        out_a_o,
  input wire logic        out_b_o,
  input wire logic        out_c_o,
  input wire logic        out_d_o
);
  logic [7:0]     ctl_q;  // Shadow control
  logic [3:0]     pol_q;  // Shadow polarity
  logic [DBW-1:0] dbr_q;  // Shadow rise dead band
  logic [DBW-1:0] dbf_q;  // Shadow fall dead band
  logic [DBW:0]   hi_q;   // Run of high input samples
  logic [DBW:0]   lo_q;   // Run of low input samples
  logic [6:0]     qc_q;   // Cycles since last write or fault
  wire            wr   = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  wire [3:0]      outs = {out_d_o, out_c_o, out_b_o, out_a_o};
  wire            ok   = ctl_q[7] & (qc_q > 7'h5A);  // Settled and on
  wire [2:0]      md   = ctl_q[2:0];
  // Shadow writes at the taking edge, count input runs
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= 8'h00;
      pol_q <= 4'hF;
      dbr_q <= '0;
      dbf_q <= '0;
      hi_q <= '0;
      lo_q <= '0;
      qc_q <= 7'h00;
    end else begin
      hi_q <= data_i ? hi_q + {{DBW{1'b0}}, ~&hi_q} : '0;
      lo_q <= data_i ? '0 : lo_q + {{DBW{1'b0}}, ~&lo_q};
      qc_q <= (wr | fault_i) ? 7'h00 : qc_q + {6'h00, ~&qc_q};
      if (wr && adr_i == `CWM_OFS_CTRL) ctl_q <= dat_i[7:0];
      if (wr && adr_i == `CWM_OFS_POL) pol_q <= dat_i[3:0];
      if (wr && adr_i == `CWM_OFS_DBR) dbr_q <= dat_i[DBW-1:0];
      if (wr && adr_i == `CWM_OFS_DBF) dbf_q <= dat_i[DBW-1:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  a_ack_after_req:
    assert property (s_req |=> ack_o) else $error("no ack after request");
  a_ack_one_pulse:
    assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_idle_when_off:
    assert property (!ctl_q[7] && $stable(ctl_q) && $stable(pol_q) |-> outs == ~pol_q)
    else $error("outputs active while disabled");
  a_fwd_levels:
    assert property (ok && md == `CWM_MODE_FWD |-> outs[2:0] == {~pol_q[2:1], pol_q[0]}
      && out_d_o == ($past(data_i) ~^ pol_q[3])) else $error("forward levels wrong");
  a_rev_levels:
    assert property (ok && md == `CWM_MODE_REV |-> {outs[3:2], outs[0]} ==
      {~pol_q[3], pol_q[2], ~pol_q[0]} && out_b_o == ($past(data_i) ~^ pol_q[1]))
    else $error("reverse levels wrong");
  a_half_rise_dead:
    assert property (ok && md == `CWM_MODE_HALF |->
      (out_a_o ~^ pol_q[0]) == (hi_q > {1'b0, dbr_q})) else $error("A dead band wrong");
  a_half_fall_dead:
    assert property (ok && md == `CWM_MODE_HALF |->
      (out_b_o ~^ pol_q[1]) == (lo_q > {1'b0, dbf_q})) else $error("B dead band wrong");
  a_mirror_cd:
    assert property (ok && (md == `CWM_MODE_HALF || md == `CWM_MODE_PP) |->
      (out_c_o ^ pol_q[2]) == (out_a_o ^ pol_q[0]) &&
      (out_d_o ^ pol_q[3]) == (out_b_o ^ pol_q[1])) else $error("C or D not mirrored");
  a_pp_alternate:
    assert property (ok && md == `CWM_MODE_PP |->
      !((out_a_o ~^ pol_q[0]) && (out_b_o ~^ pol_q[1]))) else $error("A and B both on");
  a_fault_off:
    assert property (ctl_q[7] && md[2:1] != 2'b00 && fault_i && $stable(pol_q) |->
      ##[1:2] outs == ~pol_q) else $error("outputs on during shutdown");
endmodule
bind cwm_top cwm_checker #(.DBW(DBW)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .data_i(data_i), .fault_i(fault_i), .out_a_o(out_a_o), .out_b_o(out_b_o),
  .out_c_o(out_c_o), .out_d_o(out_d_o));
`default_nettype wire

// >>> test/complementary_waveform_modes_test.sv
// Bench for cwm_top: registers, every mode, live reversal, shutdown, steering.
// Assumes the slave acks each request and the driver model sits on the outputs.
`timescale 1ns/1ps
`default_nettype none
`include "cwm_consts.vh"
module complementary_waveform_modes_test;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, data_i, fault_i;
  logic [7:0]  adr_i, lf, dv;
  logic [3:0]  sel_i, pol_v, pv;
  logic [31:0] dat_i, rd;
  logic [1:0]  s;
  wire  [31:0] dat_o;
  wire  [7:0]  shoot;
  wire         ack_o, out_a_o, out_b_o, out_c_o, out_d_o;
  wire  [3:0]  outs = {out_d_o, out_c_o, out_b_o, out_a_o};
  logic [2:0]  mt [6] = '{`CWM_MODE_HALF, `CWM_MODE_PP, `CWM_MODE_FWD,
                          `CWM_MODE_REV, `CWM_MODE_SYNC, `CWM_MODE_ASYNC};
  int          n_fail = 0, num_checks = 0;
  cwm_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .data_i(data_i), .fault_i(fault_i), .out_a_o(out_a_o), .out_b_o(out_b_o),
    .out_c_o(out_c_o), .out_d_o(out_d_o));
  cwm_bridge_model u_drv (.clk_i(clk_i), .out_i(outs), .pol_i(pol_v), .shoot_o(shoot));
  // Next pseudo-random byte
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Read-back of a 6-bit dead band field
  function automatic logic [31:0] db6(input logic [7:0] v);
    db6 = {26'h0, v[5:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 50);
    if (ack_o !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Random pulse train on the input
  task automatic run(input int n);
    repeat (n) begin
      @(posedge clk_i);
      lf = lfsr(lf);
      data_i <= lf[0] | lf[1];
    end
  endtask
  // One pulse, noting which of A and B went high
  task automatic pulse(output logic [1:0] f);
    f = 2'b00;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      data_i <= (i < 8);
      f = f | {out_b_o, out_a_o};
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, data_i, fault_i} = 6'h20;
    {adr_i, dat_i} = '0;
    sel_i = 4'hF;
    lf = 8'h30;
    pol_v = 4'hF;
    wait_n(2);
    rst_i <= 1'b0;
    wb(0, `CWM_OFS_POL, 0);
    chk(rd, 32'h0000_000F);
    wb(0, 8'h1C, 0);
    chk(rd, 32'h0000_0000);
    foreach (mt[k]) begin
      lf = lfsr(lf);
      pv = (mt[k][2:1] == 2'b00) ? 4'hF : lf[3:0];
      dv = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : lf;
      wb(1, `CWM_OFS_CTRL, {29'h0, mt[k]});
      wb(1, `CWM_OFS_POL, {28'h0, pv});
      pol_v <= pv;
      wb(1, `CWM_OFS_DBR, {24'h0, dv});
      wb(0, `CWM_OFS_DBR, 0);
      chk(rd, db6(dv));
      wb(1, `CWM_OFS_DBF, {24'h0, lfsr(lf)});
      wb(1, `CWM_OFS_STEER, (mt[k][2:1] == 2'b00) ? 32'h0000_0005 : {24'h0, lf});
      wb(1, `CWM_OFS_CTRL, {24'h0, 5'h10, mt[k]});
      run(300);
      wb(1, `CWM_OFS_CTRL, {29'h0, mt[k]});
      run(3);
      chk(outs, {28'h0, ~pol_v});
    end
    wait_n(1);
    data_i <= 1'b0;
    wb(1, `CWM_OFS_CTRL, 32'h0000_0005);
    wb(1, `CWM_OFS_POL, 32'h0000_000F);
    pol_v <= 4'hF;
    wb(1, `CWM_OFS_DBR, 0);
    wb(1, `CWM_OFS_DBF, 0);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0085);
    pulse(s);
    chk(s, 2'b01);
    pulse(s);
    chk(s, 2'b10);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0005);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0085);
    pulse(s);
    chk(s, 2'b01);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0005);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0002);
    wb(1, `CWM_OFS_DBR, 32'h0000_0003);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0082);
    pulse(s);
    chk(s, 2'b01);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0083);
    wait_n(3);
    chk(outs, 4'b0001);
    data_i <= 1'b1;
    wait_n(2);
    chk(outs, 4'b0100);
    wait_n(6);
    chk(outs, 4'b0110);
    fault_i <= 1'b1;
    wait_n(3);
    chk(outs, 4'b0000);
    wb(0, `CWM_OFS_STAT, 0);
    chk(rd[0], 1'b1);
    fault_i <= 1'b0;
    wb(1, `CWM_OFS_STAT, 32'h0000_0001);
    wb(0, `CWM_OFS_STAT, 0);
    chk(rd[0], 1'b0);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0003);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0001);
    wb(1, `CWM_OFS_STEER, 32'h0000_0001);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0081);
    wb(1, `CWM_OFS_STEER, 32'h0000_0000);
    wait_n(2);
    chk(out_a_o, 1'b1);
    data_i <= 1'b0;
    wait_n(2);
    data_i <= 1'b1;
    wait_n(3);
    chk(out_a_o, 1'b0);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0001);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0000);
    wb(1, `CWM_OFS_POL, 32'h0000_0000);
    pol_v <= 4'h0;
    wb(1, `CWM_OFS_STEER, 32'h0000_00F1);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0080);
    wait_n(2);
    chk(outs, 4'b1110);
    wb(1, `CWM_OFS_STEER, 32'h0000_00F0);
    wait_n(1);
    chk(out_a_o, 1'b1);
    // Reserved mode code keeps every output inactive
    wb(1, `CWM_OFS_CTRL, 32'h0000_0006);
    wb(1, `CWM_OFS_CTRL, 32'h0000_0086);
    wait_n(2);
    chk(outs, 4'b1111);
    chk(shoot, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
